// File: bench/scdt_chk.sv
// scdt_chk.sv: port assertions for the clock divider and trim block
// assumes binding to scdt_clock_divider; one clock domain
`default_nettype none
module scdt_chk (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        clock_out_fuse,
    input wire logic [7:0]  factoryTrim,
    input wire logic        clkEnCpu,
    input wire logic        clkEnFlash,
    input wire logic        clkEnIo,
    input wire logic        clkEnAdc,
    input wire logic        clock_out_pin_o,
    input wire logic        clock_out_pin_oe,
    input wire logic [7:0]  oscTrim,
    input wire logic        trim_range_select,
    input wire logic [6:0]  trim_fine_value
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // exactly one wait state per request
    sequence sWait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    AST_WAIT: assert property ($rose(avs_read || avs_write) |-> sWait) else $error("wait state count");
    AST_OE: assert property (clock_out_pin_oe == $past(clock_out_fuse)) else $error("pin enable");
    AST_PIN: assert property ($changed(clock_out_pin_o) |-> clkEnCpu || $past(clkEnCpu))
        else $error("pin toggles off pulse");
    AST_DOM: assert property (clkEnCpu == clkEnIo && clkEnIo == clkEnAdc && clkEnAdc == clkEnFlash)
        else $error("domains differ");
    AST_RDHI: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits");
    AST_TRST: assert property ($rose(rst_n) |=> oscTrim == factoryTrim) else $error("trim reset");
    AST_RNG: assert property (trim_range_select == oscTrim[7]) else $error("range bit");
    AST_FINE: assert property (trim_fine_value == oscTrim[6:0]) else $error("fine bits");
endmodule : scdt_chk

bind scdt_clock_divider scdt_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clock_out_fuse(clock_out_fuse), .factoryTrim(factoryTrim), .clkEnCpu(clkEnCpu), .clkEnFlash(clkEnFlash),
    .clkEnIo(clkEnIo), .clkEnAdc(clkEnAdc), .clock_out_pin_o(clock_out_pin_o),
    .clock_out_pin_oe(clock_out_pin_oe), .oscTrim(oscTrim), .trim_range_select(trim_range_select),
    .trim_fine_value(trim_fine_value));
`default_nettype wire

// File: bench/system_clock_divider_and_trim_test.sv
// system_clock_divider_and_trim_test.sv: self-checking bench for the divider and trim block
// assumes a 50 MHz clock; registers at 0x0 trim, 0x4 divider
`default_nettype none
module system_clock_divider_and_trim_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic        fuseDiv8 = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] rdata;
    logic        avs_waitrequest;
    logic        clkEnCpu, clkEnFlash, clkEnIo, clkEnAdc, pinO, pinOe, trimRange;
    logic [6:0]  trimFine;
    logic [7:0]  oscTrim;
    int          n_errors = 0;
    int          check_count = 0;
    always #10 clk_sys = ~clk_sys;
    scdt_clock_divider DUT (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .clock_out_fuse(1'b1), .initial_divide_by_eight_fuse(fuseDiv8),
        .factoryTrim(8'h5a), .clkEnCpu(clkEnCpu), .clkEnFlash(clkEnFlash), .clkEnIo(clkEnIo), .clkEnAdc(clkEnAdc),
        .clock_out_pin_o(pinO), .clock_out_pin_oe(pinOe), .oscTrim(oscTrim), .trim_range_select(trimRange),
        .trim_fine_value(trimFine));
    task summarize;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // holds the request until waitrequest is sampled low, then one idle edge
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h0);
        chk("readdata", e, rdata);
    endtask : rd
    // pulses are counted on clkEnCpu, the current system clock
    task pulses(input int k);
        repeat (k) do @(posedge clk_sys); while (clkEnCpu !== 1'b1);
    endtask : pulses
    task per(input int e);
        int n;
        pulses(2);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (clkEnCpu !== 1'b1 && n < 600);
        chk("period", e, n);
    endtask : per
    // no interrupts in the bench, so nothing splits the pair
    task setSel(input logic [3:0] c);
        bus(1'b1, 4'h4, 8'h80);
        bus(1'b1, 4'h4, {4'h0, c});
    endtask : setSel
    task tReset(input logic f);
        @(posedge clk_sys);
        fuseDiv8 <= f;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("pinOe", 1'b1, pinOe);
        rd(4'h0, 32'h5a);
        rd(4'h4, f ? 32'h3 : 32'h0);
        per(f ? 8 : 1);
        $display("reset test done");
    endtask : tReset
    task tCodes;
        for (int c = 0; c < 10; c++) begin
            setSel(c[3:0]);
            if (c < 9)
                rd(4'h4, c);
            per(c > 8 ? 256 : 1 << c);
        end
        $display("codes test done");
    endtask : tCodes
    // slow factor so bus cycles fit well inside one pulse
    task tUnlock;
        setSel(4'h8);
        bus(1'b1, 4'h4, 8'h81);
        rd(4'h4, 32'h08);
        bus(1'b1, 4'h4, 8'h80);
        rd(4'h4, 32'h88);
        pulses(2);
        bus(1'b1, 4'h4, 8'h80);
        rd(4'h4, 32'h88);
        pulses(3);
        rd(4'h4, 32'h08);
        bus(1'b1, 4'h4, 8'h05);
        rd(4'h4, 32'h08);
        bus(1'b1, 4'h4, 8'h80);
        pulses(3);
        bus(1'b1, 4'h4, 8'h02);
        rd(4'h4, 32'h02);
        per(4);
        rd(4'h8, 32'h02);
        $display("unlock test done");
    endtask : tUnlock
    task tTrim;
        bus(1'b1, 4'h0, 8'h7f);
        rd(4'h0, 32'h7f);
        chk("trim", 8'h7f, {trimRange, trimFine});
        bus(1'b1, 4'h0, 8'h80);
        bus(1'b1, 4'hc, 8'h33);
        rd(4'hc, 32'h0);
        rd(4'h0, 32'h80);
        chk("trim", 8'h80, {trimRange, trimFine});
        chk("oscTrim", 8'h80, oscTrim);
        $display("trim test done");
    endtask : tTrim
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        summarize;
    end
    initial begin
        tReset(1'b0);
        tCodes;
        tUnlock;
        tTrim;
        tReset(1'b1);
        summarize;
    end
endmodule : system_clock_divider_and_trim_test
`default_nettype wire

// File: hdl/scdt_clock_divider.sv
// scdt_clock_divider.sv: glitch-free power-of-two system clock divider, clock out pin and trim register
// assumes clk_sys is the undivided master clock; fuses and factory trim are static straps
`default_nettype none
`include "scdt_defs.svh"

module scdt_clock_divider #(
    parameter int          SelWidth  = 4,
    parameter int          DivStages = 8
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        clock_out_fuse,
    input  wire logic        initial_divide_by_eight_fuse,
    input  wire logic [7:0]  factoryTrim,
    output logic             clkEnCpu,
    output logic             clkEnFlash,
    output logic             clkEnIo,
    output logic             clkEnAdc,
    output logic             clock_out_pin_o,
    output logic             clock_out_pin_oe,
    output logic [7:0]       oscTrim,
    output logic             trim_range_select,
    output logic [6:0]       trim_fine_value
);
    logic [DivStages-1:0]   ripple_q;
    scdt_pkg::scdt_sel_t    sel_q;
    scdt_pkg::scdt_sel_t    active_q;
    scdt_pkg::scdt_sel_t    pending_q;
    scdt_pkg::scdt_state_e  state_q;
    logic                   unlock_q;
    logic [2:0]             unlockCnt_q;
    logic [7:0]             trim_q;
    logic                   ack_q;
    logic                   tick;
    logic                   tickPend;
    logic                   wrStrobe;
    logic                   rdStrobe;
    logic                   wrDiv;
    logic                   wrTrim;
    logic                   selWrite;
    logic                   unlockWrite;
    logic [DivStages:0]     tap;

    // one wait state: write taken when ack_q is high; read data loaded one edge early so it stands then
    assign wrStrobe = avs_write && ack_q;
    assign rdStrobe = avs_read && !ack_q;
    assign wrDiv    = wrStrobe && avs_address == `SCDT_OFS_DIVCTL && avs_byteenable[0];
    assign wrTrim   = wrStrobe && avs_address == `SCDT_OFS_TRIM && avs_byteenable[0];
    assign unlockWrite = wrDiv && avs_writedata[7:0] == 8'h80;
    assign selWrite    = wrDiv && !avs_writedata[`SCDT_UNLOCK_BIT] && unlock_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            ack_q           <= (avs_read || avs_write) && !ack_q;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
        end
    end

    // ripple count of master clock edges, never visible to software
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ripple_q <= '0;
        end else begin
            ripple_q <= ripple_q + 1'b1;
        end
    end

    // tap[n] is high on the one master cycle in 2^n that ends a divided period
    genvar gi;
    assign tap[0] = 1'b1;
    generate
        for (gi = 1; gi <= DivStages; gi++) begin : g_tap
            assign tap[gi] = &ripple_q[gi-1:0];
        end
    endgenerate

    // codes above 8 are reserved; they are treated as the slowest factor
    function automatic logic pick(input logic [DivStages:0] t, input scdt_pkg::scdt_sel_t s);
        logic r;
        r = t[DivStages];
        if (s <= `SCDT_SEL_MAX) begin
            r = t[s];
        end
        return r;
    endfunction : pick

    assign tick     = pick(tap, active_q);
    assign tickPend = pick(tap, pending_q);

    // switch only at an old edge, then wait for a new edge: no short period either side
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q   <= scdt_pkg::SCDT_RUN;
            active_q  <= initial_divide_by_eight_fuse ? `SCDT_SEL_RST_DIV8 : `SCDT_SEL_RST_PLAIN;
            pending_q <= initial_divide_by_eight_fuse ? `SCDT_SEL_RST_DIV8 : `SCDT_SEL_RST_PLAIN;
        end else begin
            case (state_q)
                scdt_pkg::SCDT_RUN: begin
                    if (sel_q != active_q) begin
                        pending_q <= sel_q;
                        state_q   <= scdt_pkg::SCDT_HOLD;
                    end
                end
                scdt_pkg::SCDT_HOLD: begin
                    if (tick) begin
                        state_q <= scdt_pkg::SCDT_SWITCH;
                    end
                end
                scdt_pkg::SCDT_SWITCH: begin
                    if (tickPend) begin
                        active_q <= pending_q;
                        state_q  <= scdt_pkg::SCDT_RUN;
                    end
                end
                default: begin
                    state_q <= scdt_pkg::SCDT_RUN;
                end
            endcase
        end
    end

    // during the gap no enable is given, so no period is shorter than old or new
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clkEnCpu   <= 1'b0;
            clkEnFlash <= 1'b0;
            clkEnIo    <= 1'b0;
            clkEnAdc   <= 1'b0;
        end else begin
            clkEnCpu   <= (state_q == scdt_pkg::SCDT_SWITCH) ? tickPend : tick;
            clkEnFlash <= (state_q == scdt_pkg::SCDT_SWITCH) ? tickPend : tick;
            clkEnIo    <= (state_q == scdt_pkg::SCDT_SWITCH) ? tickPend : tick;
            clkEnAdc   <= (state_q == scdt_pkg::SCDT_SWITCH) ? tickPend : tick;
        end
    end

    // pin toggles on each divided edge; driven also while rst_n is low
    always_ff @(posedge clk_sys) begin
        clock_out_pin_oe <= clock_out_fuse;
        if (!rst_n) begin
            clock_out_pin_o <= 1'b0;
        end else if (!clock_out_fuse) begin
            clock_out_pin_o <= 1'b0;
        end else if (state_q == scdt_pkg::SCDT_SWITCH ? tickPend : tick) begin
            clock_out_pin_o <= !clock_out_pin_o;
        end
    end

    // unlock window: a divided-cycle count; only a select write cuts it short
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            unlock_q    <= 1'b0;
            unlockCnt_q <= '0;
        end else if (selWrite) begin
            unlock_q    <= 1'b0;
            unlockCnt_q <= '0;
        end else if (unlock_q) begin
            if (clkEnCpu) begin
                unlockCnt_q <= unlockCnt_q + 3'h1;
                if (unlockCnt_q + 3'h1 == `SCDT_UNLOCK_CYCLES) begin
                    unlock_q <= 1'b0;
                end
            end
        end else if (unlockWrite) begin
            unlock_q    <= 1'b1;
            unlockCnt_q <= '0;
        end
    end
    // a rewrite while open falls into the counting branch untouched

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sel_q <= initial_divide_by_eight_fuse ? `SCDT_SEL_RST_DIV8 : `SCDT_SEL_RST_PLAIN;
        end else if (selWrite) begin
            sel_q <= avs_writedata[`SCDT_SEL_MSB:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trim_q <= factoryTrim;
        end else if (wrTrim) begin
            trim_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oscTrim           <= `SCDT_TRIM_FACTORY;
            trim_range_select <= 1'b1;
            trim_fine_value   <= '0;
        end else begin
            oscTrim           <= trim_q;
            trim_range_select <= trim_q[7];
            trim_fine_value   <= trim_q[6:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (rdStrobe) begin
            case (avs_address)
                `SCDT_OFS_TRIM:   avs_readdata <= {24'h000000, trim_q};
                `SCDT_OFS_DIVCTL: avs_readdata <= {24'h000000, unlock_q, 3'h0, sel_q};
                `SCDT_OFS_STATUS: avs_readdata <= {24'h000000, 3'h0, state_q != scdt_pkg::SCDT_RUN, active_q};
                default:          avs_readdata <= '0;
            endcase
        end
    end
endmodule : scdt_clock_divider
`default_nettype wire

// File: hdl/scdt_defs.svh
// scdt_defs.svh: offsets, fields, reset values and counts of the clock divider and trim block
// assumes inclusion by bare name from the design file; the bench files do not include it
`ifndef SCDT_DEFS_SVH
`define SCDT_DEFS_SVH

`define SCDT_OFS_TRIM        4'h0
`define SCDT_OFS_DIVCTL      4'h4
`define SCDT_OFS_STATUS      4'h8
`define SCDT_UNLOCK_BIT      7
`define SCDT_SEL_MSB         3
`define SCDT_SEL_MAX         4'h8
`define SCDT_SEL_RST_PLAIN   4'h0
`define SCDT_SEL_RST_DIV8    4'h3
`define SCDT_UNLOCK_CYCLES   3'h4
`define SCDT_TRIM_FACTORY    8'h80

`endif

// File: hdl/scdt_pkg.sv
// scdt_pkg.sv: types shared by the clock divider and trim block
// assumes nothing from scdt_defs.svh; the package uses none of its constants
`default_nettype none
package scdt_pkg;
    typedef enum logic [1:0] {
        SCDT_RUN,
        SCDT_HOLD,
        SCDT_SWITCH
    } scdt_state_e;
    typedef logic [3:0] scdt_sel_t;
endpackage : scdt_pkg
`default_nettype wire
